// [design/rscd_strap_loader.sv]
// Strap capture, ROM signature check and configuration decode
module rscd_strap_loader
  import rscd_pkg::*;
#(
  parameter int unsigned ROM_TIMEOUT_CYC = ROM_TIMEOUT_DEF_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Detected pulls on the serial strap pins
  input wire logic [1:0] i_rom_data_out_pull,
  input wire logic [1:0] i_rom_clock_pull,
  // Resistor classes on the multi-level straps
  input wire logic [2:0] i_fixed_port_strap,
  input wire logic [2:0] i_charge_port_strap,
  input wire logic [2:0] i_pin_mode_strap,
  // Port disable strap levels
  input wire logic [3:0] i_port_pos_line_disable,
  input wire logic [3:0] i_port_neg_line_disable,
  // ROM reader
  output logic o_rom_read_req,
  output logic [15:0] o_rom_addr,
  input wire logic i_rom_byte_valid,
  input wire logic [7:0] i_rom_byte,
  input wire logic i_rom_error,
  // Hub register setup for bridging
  input wire logic i_bridge_setup_done,
  // Decoded configuration
  output logic o_cfg_valid,
  output logic [1:0] o_serial_mode,
  output logic o_spi_en,
  output logic o_smbus_en,
  output logic o_i2c_bridge_en,
  output logic o_uart_en,
  output logic [3:0] o_port_disable,
  output logic [3:0] o_ss_port_disable,
  output logic [3:0] o_fixed_ports,
  output logic [3:0] o_charge_ports,
  output logic [2:0] o_pin_config,
  output logic o_pin_config_reserved
);

  localparam int unsigned SYNC_W = 21;

  // Synchronised strap bus, free running even during reset
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  // Latched strap levels
  logic [1:0] do_pull_ff;
  logic [1:0] clk_pull_ff;
  logic [2:0] fixed_cls_ff;
  logic [2:0] charge_cls_ff;
  logic [2:0] pin_cls_ff;
  logic [3:0] pos_dis_ff;
  logic [3:0] neg_dis_ff;
  // Sequencer and ROM check
  rscd_state_type state_ff;
  logic [1:0] sig_idx_ff;
  logic [15:0] rom_timer_ff;
  logic sig_ok_ff;
  // Decode results
  logic [1:0] nxt_mode;
  logic [2:0] nxt_pin;
  logic [3:0] nxt_dis;
  logic pin_ok;
  logic sig_byte_ok;
  logic rom_fail;
  logic [7:0] exp_byte;
  logic [1:0] sig_shift;

  rscd_cls_if fixed_if ();
  rscd_cls_if charge_if ();

  // Two flops on every strap input; the strap levels are seen in reset
  always_ff @(posedge i_mclk) begin
    sync1_ff <= {i_rom_data_out_pull, i_rom_clock_pull, i_fixed_port_strap,
                 i_charge_port_strap, i_pin_mode_strap, i_port_pos_line_disable,
                 i_port_neg_line_disable}; // R1
    sync2_ff <= sync1_ff;
  end

  // Latch the strap levels on the first edge after reset release
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      do_pull_ff <= PULL_NONE;
      clk_pull_ff <= PULL_NONE;
      fixed_cls_ff <= RES_200K_PD;
      charge_cls_ff <= RES_200K_PD;
      pin_cls_ff <= RES_200K_PD;
      pos_dis_ff <= MASK_NONE;
      neg_dis_ff <= MASK_NONE;
    end else if (state_ff == ST_LATCH) begin
      do_pull_ff <= sync2_ff[20:19]; // R1
      clk_pull_ff <= sync2_ff[18:17]; // R1
      fixed_cls_ff <= sync2_ff[16:14]; // R1
      charge_cls_ff <= sync2_ff[13:11]; // R1
      pin_cls_ff <= sync2_ff[10:8]; // R1
      pos_dis_ff <= sync2_ff[7:4]; // R1
      neg_dis_ff <= sync2_ff[3:0]; // R1
    end
  end

  // Expected signature byte, first character at the lowest address
  assign sig_shift = SIG_LAST - sig_idx_ff;
  assign exp_byte = 8'(ROM_SIG >> {sig_shift, 3'h0});
  assign sig_byte_ok = (i_rom_byte == exp_byte); // R6
  assign rom_fail = i_rom_error || (rom_timer_ff >= 16'(ROM_TIMEOUT_CYC - 1)) ||
                    (i_rom_byte_valid && !sig_byte_ok);

  // Sequencer: latch, classify, optional ROM check, then hold
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= ST_LATCH;
    end else begin
      case (state_ff)
        ST_LATCH: state_ff <= ST_EVAL;
        ST_EVAL: begin
          if (nxt_mode == SER_SPI) begin
            state_ff <= ST_ROM; // R4
          end else begin
            state_ff <= ST_DONE;
          end
        end
        ST_ROM: begin
          if (rom_fail || (i_rom_byte_valid && sig_idx_ff == SIG_LAST)) begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: state_ff <= ST_DONE; // R17
        default: state_ff <= ST_LATCH;
      endcase
    end
  end

  // Signature walk and timeout while the ROM is being read
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sig_idx_ff <= 2'h0;
      rom_timer_ff <= 16'h0000;
      sig_ok_ff <= 1'b0;
    end else if (state_ff == ST_ROM) begin
      rom_timer_ff <= rom_timer_ff + 16'h0001;
      if (i_rom_byte_valid && sig_byte_ok) begin
        sig_idx_ff <= sig_idx_ff + 2'h1;
        if (sig_idx_ff == SIG_LAST && !i_rom_error) begin
          sig_ok_ff <= 1'b1; // R6
        end
      end
    end
  end

  // ROM request stands for the whole check at the signature address
  assign o_rom_read_req = (state_ff == ST_ROM);
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_rom_addr <= 16'h0000;
    end else if (state_ff == ST_EVAL) begin
      o_rom_addr <= ROM_SIG_ADDR; // R6
    end
  end

  // Serial mode from the latched pulls; the ROM outcome refines SPI
  always_comb begin
    if (do_pull_ff == PULL_DOWN) begin
      nxt_mode = SER_UART; // R3
    end else if (do_pull_ff == PULL_UP && clk_pull_ff == PULL_UP) begin
      nxt_mode = SER_SMBUS; // R2
    end else if (state_ff == ST_ROM && rom_fail) begin
      nxt_mode = SER_I2C; // R5
    end else begin
      nxt_mode = SER_SPI; // R4
    end
  end

  // Pin configuration from the latched resistor class
  always_comb begin
    case (pin_cls_ff)
      RES_200K_PD: nxt_pin = PIN_MIXED; // R14
      RES_200K_PU: nxt_pin = PIN_SWAP; // R14
      RES_10K_PD: nxt_pin = PIN_SPEED; // R14
      RES_10K_PU: nxt_pin = PIN_GPIO; // R14
      RES_10R_PD: nxt_pin = PIN_CHARGE; // R14
      RES_10R_PU: nxt_pin = PIN_UART; // R14
      default: nxt_pin = PIN_MIXED;
    endcase
  end
  assign pin_ok = (nxt_pin != PIN_GPIO) && (nxt_pin != PIN_CHARGE); // R8 R9

  // Per-port disable needs both line straps high
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign nxt_dis[p] = pos_dis_ff[p] & neg_dis_ff[p]; // R10 R11
  end

  // Multi-level straps that share the ROM select and data-in pins
  assign fixed_if.cls = fixed_cls_ff;
  assign charge_if.cls = charge_cls_ff;
  rscd_cls_dec u_fixed_dec (
    .bus(fixed_if.dec)
  );
  rscd_cls_dec u_charge_dec (
    .bus(charge_if.dec)
  );

  // Publish once on entry to the hold state; defaults stay until then
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_cfg_valid <= 1'b0; // R18
      o_serial_mode <= SER_SPI;
      o_port_disable <= MASK_NONE;
      o_ss_port_disable <= MASK_NONE;
      o_fixed_ports <= MASK_NONE;
      o_charge_ports <= MASK_NONE;
      o_pin_config <= PIN_NONE;
      o_pin_config_reserved <= 1'b0;
    end else if (state_ff != ST_DONE && !o_cfg_valid &&
                 ((state_ff == ST_EVAL && nxt_mode != SER_SPI) ||
                  (state_ff == ST_ROM && (rom_fail ||
                   (i_rom_byte_valid && sig_idx_ff == SIG_LAST))))) begin
      o_cfg_valid <= 1'b1; // R18
      o_serial_mode <= nxt_mode;
      o_port_disable <= nxt_dis; // R11
      o_ss_port_disable <= nxt_dis; // R11
      o_pin_config <= nxt_pin; // R14
      o_pin_config_reserved <= (nxt_pin == PIN_GPIO); // R15
      if (nxt_mode == SER_SPI) begin
        o_fixed_ports <= MASK_NONE; // R16
        o_charge_ports <= MASK_NONE; // R16
      end else begin
        o_fixed_ports <= fixed_if.mask; // R12 R16
        o_charge_ports <= charge_if.mask; // R13 R16
      end
    end
  end

  // Interface enables, one serial function at a time
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_spi_en <= 1'b0;
      o_smbus_en <= 1'b0;
      o_i2c_bridge_en <= 1'b0;
      o_uart_en <= 1'b0;
    end else begin
      o_spi_en <= o_cfg_valid && o_serial_mode == SER_SPI; // R7
      o_uart_en <= o_cfg_valid && o_serial_mode == SER_UART; // R7
      o_smbus_en <= o_cfg_valid && o_serial_mode == SER_SMBUS && pin_ok; // R8
      o_i2c_bridge_en <= o_cfg_valid && o_serial_mode == SER_I2C && pin_ok &&
                         i_bridge_setup_done; // R9
    end
  end

  // Checks

  sequence s_rom_check_fails;
    (state_ff == ST_ROM) && rom_fail;
  endsequence

  sequence s_published_i2c;
    o_cfg_valid && (o_serial_mode == SER_I2C);
  endsequence

  property p_hold_after_publish;
    @(posedge i_mclk) disable iff (i_reset)
      o_cfg_valid |=> o_cfg_valid && $stable(o_serial_mode) && $stable(o_port_disable) &&
                      $stable(o_fixed_ports) && $stable(o_charge_ports) &&
                      $stable(o_pin_config);
  endproperty
  a_hold_after_publish: assert property (p_hold_after_publish) // R17
    else $error("published configuration changed");

  property p_smbus_from_pulls;
    @(posedge i_mclk) disable iff (i_reset)
      (o_cfg_valid && o_serial_mode == SER_SMBUS) |->
        (do_pull_ff == PULL_UP && clk_pull_ff == PULL_UP);
  endproperty
  a_smbus_from_pulls: assert property (p_smbus_from_pulls) // R2
    else $error("SMBus mode without both pull-ups");

  property p_uart_from_pull;
    @(posedge i_mclk) disable iff (i_reset)
      (o_cfg_valid && do_pull_ff == PULL_DOWN) |-> (o_serial_mode == SER_UART);
  endproperty
  a_uart_from_pull: assert property (p_uart_from_pull) // R3
    else $error("data-out pull-down did not give UART");

  property p_fallback_to_i2c;
    @(posedge i_mclk) disable iff (i_reset)
      s_rom_check_fails |=> s_published_i2c ##1 (o_serial_mode == SER_I2C);
  endproperty
  a_fallback_to_i2c: assert property (p_fallback_to_i2c) // R5
    else $error("failed ROM check did not give bridging mode");

  property p_spi_needs_signature;
    @(posedge i_mclk) disable iff (i_reset)
      o_spi_en |-> sig_ok_ff && o_rom_addr == ROM_SIG_ADDR;
  endproperty
  a_spi_needs_signature: assert property (p_spi_needs_signature) // R6
    else $error("SPI enabled without signature");

  property p_exclusive;
    @(posedge i_mclk) disable iff (i_reset)
      !(o_uart_en && (o_smbus_en || o_spi_en)) && !(o_smbus_en && o_i2c_bridge_en);
  endproperty
  a_exclusive: assert property (p_exclusive) // R7
    else $error("conflicting serial interfaces active");

  property p_smbus_pin_config;
    @(posedge i_mclk) disable iff (i_reset)
      o_smbus_en |-> o_pin_config != PIN_GPIO && o_pin_config != PIN_CHARGE;
  endproperty
  a_smbus_pin_config: assert property (p_smbus_pin_config) // R8
    else $error("SMBus enabled in configuration 4 or 5");

  property p_bridge_needs_setup;
    @(posedge i_mclk) disable iff (i_reset)
      o_i2c_bridge_en |-> $past(i_bridge_setup_done) && o_serial_mode == SER_I2C;
  endproperty
  a_bridge_needs_setup: assert property (p_bridge_needs_setup) // R9
    else $error("bridging enabled without setup");

  property p_port_disable;
    @(posedge i_mclk) disable iff (i_reset)
      o_cfg_valid |-> o_port_disable == (pos_dis_ff & neg_dis_ff) &&
                      o_ss_port_disable == o_port_disable;
  endproperty
  a_port_disable: assert property (p_port_disable) // R11
    else $error("port disable mismatch");

  property p_reserved_flag;
    @(posedge i_mclk) disable iff (i_reset)
      o_cfg_valid |-> o_pin_config_reserved == (o_pin_config == PIN_GPIO);
  endproperty
  a_reserved_flag: assert property (p_reserved_flag) // R15
    else $error("reserved flag wrong");

  property p_spi_no_reuse;
    @(posedge i_mclk) disable iff (i_reset)
      (o_cfg_valid && o_serial_mode == SER_SPI) |->
        o_fixed_ports == MASK_NONE && o_charge_ports == MASK_NONE;
  endproperty
  a_spi_no_reuse: assert property (p_spi_no_reuse) // R16
    else $error("strap masks used in SPI mode");

  property p_defaults_before_publish;
    @(posedge i_mclk) disable iff (i_reset)
      !o_cfg_valid |-> !o_spi_en && !o_uart_en && o_pin_config == PIN_NONE;
  endproperty
  a_defaults_before_publish: assert property (p_defaults_before_publish) // R18
    else $error("configuration shown before publish");

endmodule // rscd_strap_loader

// [design/rscd_pkg.sv]
// Constants and types for the reset strap configuration loader
//
// Behaviour
// [R1] Sample all straps while reset is active, latch them at reset release.
// [R2] Pull-ups on ROM data-out and clock straps select SMBus slave mode.
// [R3] Pull-down on ROM data-out strap selects UART mode.
// [R4] No pull on either strap puts the serial pins first in SPI mode.
// [R5] From SPI mode, fall back to I2C bridging when no valid ROM.
// [R6] ROM is valid only with the four-character signature at 0xFFFA.
// [R7] Never UART with SMBus, UART with SPI, or SMBus with bridging.
// [R8] SMBus slave usable only with pin configuration 1, 2, 3 or 6.
// [R9] Bridging needs its strap, configuration 1, 2, 3 or 6, and register setup.
// [R10] Each port's two disable straps decode 0 as enabled, 1 as disabled.
// [R11] Port disabled only if both straps high; also disables its 5 Gbps port.
// [R12] Fixed-port strap decodes five resistor settings into 0 to 4 fixed ports.
// [R13] Charge-port strap decodes five resistor settings into 0 to 4 charging ports.
// [R14] Pin-mode strap decodes six resistor settings into configurations 1 to 6.
// [R15] Pin configuration 4, the GPIO mode, is flagged reserved.
// [R16] Outside SPI mode, chip-select and data-in pins carry fixed and charge straps.
// [R17] Latched and decoded values stay constant until the next reset.
// [R18] Decoded values appear only after release; defaults hold during reset.
package rscd_pkg;

  // Pull detected on a serial strap pin
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;

  // Resistor class reported by the strap detector
  localparam logic [2:0] RES_200K_PD = 3'h0;
  localparam logic [2:0] RES_200K_PU = 3'h1;
  localparam logic [2:0] RES_10K_PD = 3'h2;
  localparam logic [2:0] RES_10K_PU = 3'h3;
  localparam logic [2:0] RES_10R_PD = 3'h4;
  localparam logic [2:0] RES_10R_PU = 3'h5;

  // Serial pin modes
  localparam logic [1:0] SER_SPI = 2'h0;
  localparam logic [1:0] SER_SMBUS = 2'h1;
  localparam logic [1:0] SER_I2C = 2'h2;
  localparam logic [1:0] SER_UART = 2'h3;

  // Programmable pin configurations, zero means not yet decoded
  localparam logic [2:0] PIN_NONE = 3'h0;
  localparam logic [2:0] PIN_MIXED = 3'h1;
  localparam logic [2:0] PIN_SWAP = 3'h2;
  localparam logic [2:0] PIN_SPEED = 3'h3;
  localparam logic [2:0] PIN_GPIO = 3'h4;
  localparam logic [2:0] PIN_CHARGE = 3'h5;
  localparam logic [2:0] PIN_UART = 3'h6;

  // Port masks
  localparam int unsigned NUM_PORTS = 4;
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [3:0] MASK_P1 = 4'h1;
  localparam logic [3:0] MASK_P12 = 4'h3;
  localparam logic [3:0] MASK_P123 = 4'h7;
  localparam logic [3:0] MASK_P1234 = 4'hF;

  // ROM signature check
  localparam logic [15:0] ROM_SIG_ADDR = 16'hFFFA;
  localparam logic [31:0] ROM_SIG = 32'h32444655;
  localparam logic [1:0] SIG_LAST = 2'h3;

  // Timing: ROM answer timeout
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned ROM_TIMEOUT_US = 100;
  localparam int unsigned ROM_TIMEOUT_DEF_CYC = ROM_TIMEOUT_US * CLK_MHZ;

  // Loader sequence
  typedef enum logic [1:0] {
    ST_LATCH,
    ST_EVAL,
    ST_ROM,
    ST_DONE
  } rscd_state_type;

endpackage : rscd_pkg

// [design/rscd_cls_if.sv]
// Carrier between the loader and a resistor-class decoder
interface rscd_cls_if;
  logic [2:0] cls;
  logic [3:0] mask;
  modport host (output cls, input mask);
  modport dec (input cls, output mask);
endinterface : rscd_cls_if

// [design/rscd_cls_dec.sv]
// Resistor class to port-count mask decoder
module rscd_cls_dec
  import rscd_pkg::*;
(
  // Class in, mask out
  rscd_cls_if.dec bus
);

  // Five settings map to 0..4 leading ports; the unused class gives none
  always_comb begin
    case (bus.cls)
      RES_200K_PD: bus.mask = MASK_NONE; // R12 R13
      RES_200K_PU: bus.mask = MASK_P1; // R12 R13
      RES_10K_PD: bus.mask = MASK_P12; // R12 R13
      RES_10K_PU: bus.mask = MASK_P123; // R12 R13
      RES_10R_PD: bus.mask = MASK_P1234; // R12 R13
      default: bus.mask = MASK_NONE;
    endcase
  end

endmodule // rscd_cls_dec

// [verif/rscd_rom_model.sv]
// Behavioural strap-side ROM that answers the signature read
module rscd_rom_model
  import rscd_pkg::*;
(
  // Clock
  input wire logic i_mclk,
  // Request from the loader
  input wire logic i_rom_read_req,
  // Behaviour select: 0 good, 1 bad byte, 2 error, 3 silent
  input wire logic [1:0] i_mode,
  input wire logic [1:0] i_gap,
  input wire logic [1:0] i_bad_idx,
  // Answer lines
  output logic o_rom_byte_valid,
  output logic [7:0] o_rom_byte,
  output logic o_rom_error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] idx_ff;
  logic [1:0] wait_ff;
  logic [7:0] sig_byte;

  // Signature characters in address order
  always_comb begin
    case (idx_ff[1:0])
      2'h0: sig_byte = 8'h32;
      2'h1: sig_byte = 8'h44;
      2'h2: sig_byte = 8'h46;
      default: sig_byte = 8'h55;
    endcase
  end

  // Start quiet
  initial begin
    o_rom_byte_valid = 1'b0;
    o_rom_byte = 8'h00;
    o_rom_error = 1'b0;
    idx_ff = 3'h0;
    wait_ff = 2'h0;
  end

  // Answer on the falling edge; a released data line keeps toggling
  always @(negedge i_mclk) begin
    o_rom_byte_valid <= 1'b0;
    o_rom_error <= 1'b0;
    o_rom_byte <= ~o_rom_byte;
    if (!i_rom_read_req) begin
      idx_ff <= 3'h0;
      wait_ff <= i_gap;
    end else if (wait_ff != 2'h0) begin
      wait_ff <= wait_ff - 2'h1;
    end else if (idx_ff < 3'h4) begin
      wait_ff <= i_gap;
      case (i_mode)
        2'h0, 2'h1: begin
          o_rom_byte_valid <= 1'b1;
          o_rom_byte <= (i_mode == 2'h1 && idx_ff[1:0] == i_bad_idx) ? ~sig_byte : sig_byte;
          idx_ff <= idx_ff + 3'h1;
        end
        2'h2: begin
          o_rom_error <= 1'b1;
          idx_ff <= 3'h4;
        end
        default: ; // Silent ROM, loader must time out
      endcase
    end
  end
endmodule // rscd_rom_model

// [verif/tb_rscd_strap_loader.sv]
// Self-checking bench for the strap loader
module tb_rscd_strap_loader
  import rscd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TO_CYC = 20;
  logic i_mclk, i_reset, rv, re, setup, req, cfg_valid, spi_en, smb_en, i2c_en, uart_en, res;
  logic [1:0] dp, cp, rmode, gap, bad, smode;
  logic [2:0] fx, ch, pm, pcfg;
  logic [3:0] pos, neg, pdis, ssdis, fixm, chm;
  logic [7:0] rbyte;
  logic [15:0] raddr;
  int errors = 0;
  int samples_checked = 0;
  bit hung = 1'b0;

  rscd_strap_loader #(.ROM_TIMEOUT_CYC(TO_CYC)) i_rscd_strap_loader (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_rom_data_out_pull(dp), .i_rom_clock_pull(cp),
    .i_fixed_port_strap(fx), .i_charge_port_strap(ch), .i_pin_mode_strap(pm),
    .i_port_pos_line_disable(pos), .i_port_neg_line_disable(neg),
    .o_rom_read_req(req), .o_rom_addr(raddr), .i_rom_byte_valid(rv), .i_rom_byte(rbyte),
    .i_rom_error(re), .i_bridge_setup_done(setup), .o_cfg_valid(cfg_valid),
    .o_serial_mode(smode), .o_spi_en(spi_en), .o_smbus_en(smb_en), .o_i2c_bridge_en(i2c_en),
    .o_uart_en(uart_en), .o_port_disable(pdis), .o_ss_port_disable(ssdis),
    .o_fixed_ports(fixm), .o_charge_ports(chm), .o_pin_config(pcfg),
    .o_pin_config_reserved(res));

  rscd_rom_model i_rscd_rom_model (
    .i_mclk(i_mclk), .i_rom_read_req(req), .i_mode(rmode), .i_gap(gap), .i_bad_idx(bad),
    .o_rom_byte_valid(rv), .o_rom_byte(rbyte), .o_rom_error(re));

  // Clock at 50 MHz
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  // Verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Compare one value
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Expected serial mode from the pulls and the ROM outcome
  function automatic logic [1:0] exp_mode(logic [1:0] d, logic [1:0] c, logic ok);
    if (d == PULL_DOWN) return SER_UART;
    if (d == PULL_UP && c == PULL_UP) return SER_SMBUS;
    return ok ? SER_SPI : SER_I2C;
  endfunction

  // Expected port mask from a resistor class
  function automatic logic [3:0] exp_mask(logic [2:0] c);
    case (c)
      RES_200K_PU: return MASK_P1;
      RES_10K_PD: return MASK_P12;
      RES_10K_PU: return MASK_P123;
      RES_10R_PD: return MASK_P1234;
      default: return MASK_NONE;
    endcase
  endfunction

  // Random strap levels; a lone clock pull is left out
  task automatic rand_straps();
    dp = 2'($urandom_range(2, 0));
    cp = (dp == PULL_NONE) ? PULL_NONE : 2'($urandom_range(2, 0));
    fx = 3'($urandom_range(5, 0));
    ch = 3'($urandom_range(5, 0));
    pm = 3'($urandom_range(5, 0));
    pos = 4'($urandom);
    neg = 4'($urandom);
  endtask

  // One reset, publish and compare cycle
  task automatic run_test(input int tn);
    logic [1:0] em;
    logic [2:0] epc;
    logic [3:0] efx, ech, edis;
    logic ok45, seen_req;
    int n;
    if (hung) return;
    seen_req = 1'b0;
    i_reset = 1'b1;
    repeat (4) @(negedge i_mclk);
    check(cfg_valid, 1'b0);
    check(pcfg, PIN_NONE);
    check(spi_en | smb_en | i2c_en | uart_en, 1'b0);
    em = exp_mode(dp, cp, rmode == 2'h0);
    epc = pm + 3'h1;
    ok45 = (epc != PIN_GPIO) && (epc != PIN_CHARGE);
    efx = (em == SER_SPI) ? MASK_NONE : exp_mask(fx);
    ech = (em == SER_SPI) ? MASK_NONE : exp_mask(ch);
    edis = pos & neg;
    i_reset = 1'b0;
    n = 0;
    while (cfg_valid !== 1'b1 && n < 60) begin
      @(negedge i_mclk);
      n++;
      if (req === 1'b1 && !seen_req) begin
        seen_req = 1'b1;
        check(raddr, ROM_SIG_ADDR);
      end
    end
    if (cfg_valid !== 1'b1) begin
      errors++;
      hung = 1'b1;
      return;
    end
    rand_straps();
    repeat (3) @(negedge i_mclk);
    check(cfg_valid, 1'b1);
    check(smode, em);
    check(pcfg, epc);
    check(res, epc == PIN_GPIO);
    check(pdis, edis);
    check(ssdis, edis);
    check(fixm, efx);
    check(chm, ech);
    check(spi_en, em == SER_SPI);
    check(uart_en, em == SER_UART);
    check(smb_en, em == SER_SMBUS && ok45);
    check(i2c_en, em == SER_I2C && ok45 && setup);
    check(req, 1'b0);
    if (em == SER_I2C && ok45) begin
      setup = ~setup;
      repeat (3) @(negedge i_mclk);
      check(i2c_en, setup);
    end
    $display("test %0d done", tn);
  endtask

  // Corner table, then random runs
  initial begin
    logic [1:0] dtab [6];
    logic [1:0] ctab [6];
    dtab = '{PULL_UP, PULL_DOWN, PULL_NONE, PULL_UP, PULL_DOWN, PULL_NONE};
    ctab = '{PULL_UP, PULL_NONE, PULL_NONE, PULL_NONE, PULL_DOWN, PULL_NONE};
    i_reset = 1'b1;
    setup = 1'b1;
    rmode = 2'h0;
    gap = 2'h0;
    bad = 2'h0;
    dp = PULL_NONE;
    cp = PULL_NONE;
    fx = 3'h0;
    ch = 3'h0;
    pm = 3'h0;
    pos = 4'hF;
    neg = 4'h5;
    void'($urandom(5));
    @(negedge i_mclk);
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 6; i++) begin
        dp = dtab[i];
        cp = ctab[i];
        fx = 3'(i);
        ch = 3'(5 - i);
        pm = 3'((i + 3 * j) % 6);
        rmode = 2'(i % 4);
        bad = 2'(i + j);
        pos = 4'hF;
        neg = 4'(5 + 5 * j);
        run_test(i + 6 * j);
      end
    end
    for (int t = 12; t < 52; t++) begin
      rand_straps();
      rmode = 2'($urandom_range(3, 0));
      gap = 2'($urandom_range(2, 0));
      bad = 2'($urandom);
      setup = 1'($urandom);
      run_test(t);
    end
    finish_test();
  end
endmodule // tb_rscd_strap_loader
